// >>> bench/nvsram_host_assertions.sv
`timescale 1ns/1ps
module nvsram_host_assertions
	import nvsram_host_pkg::*;
(
	input wire logic       clock_in,
	input wire logic       rst_b_in,
	input wire logic [1:0] req_op_in,
	input wire logic       req_ready_out,
	input wire logic       rsp_valid_out,
	input wire logic       busy_out,
	input wire logic       mem_chip_sel_n_out,
	input wire logic       mem_write_n_out,
	input wire logic       mem_out_en_n_out,
	input wire logic       mem_dq_oe_out,
	input wire logic       store_busy_n_in,
	input wire logic       store_busy_n_out,
	input wire logic       store_busy_n_oe_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	logic cmd_on_q;
	// marks a soft command from its acceptance until busy_out drops
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cmd_on_q <= 1'h0;
		end else if (req_ready_out && req_op_in == OP_SOFT_CMD) begin
			cmd_on_q <= 1'h1;
		end else if (!busy_out) begin
			cmd_on_q <= 1'h0;
		end
	end
	a_read_len: assert property (
		$rose(!mem_chip_sel_n_out && !mem_out_en_n_out) |->
		(!mem_chip_sel_n_out && !mem_out_en_n_out) [*2])
		else $error("read strobe too short");
	a_drive_low: assert property (
		store_busy_n_oe_out |-> !store_busy_n_out)
		else $error("store pin driven high");
	a_no_access: assert property (
		!store_busy_n_in [*3] |-> mem_chip_sel_n_out && mem_write_n_out)
		else $error("access while store pin low");
	a_cmd_quiet: assert property (
		cmd_on_q |-> mem_write_n_out && !rsp_valid_out)
		else $error("write or answer in command");
	a_cmd_done: assert property (
		req_ready_out && req_op_in == OP_SOFT_CMD |-> ##[1:300] !busy_out)
		else $error("command never ends");
	a_write_dq: assert property (
		!mem_write_n_out |-> !mem_chip_sel_n_out && mem_dq_oe_out)
		else $error("write without select or data");
	a_read_answer: assert property (
		req_ready_out && req_op_in == OP_READ |-> ##[1:4] rsp_valid_out)
		else $error("read not answered");
endmodule // nvsram_host_assertions
bind nvsram_host nvsram_host_assertions chk (.*);

// >>> bench/nvsram_model.sv
`timescale 1ns/1ps
module nvsram_model (
	input  wire logic [14:0] addr_in,
	input  wire logic        chip_sel_n_in,
	input  wire logic        write_n_in,
	input  wire logic        out_en_n_in,
	input  wire logic [7:0]  dq_in,
	input  wire logic        busy_drv_in,
	output logic      [7:0]  dq_out,
	output logic             store_busy_n_out
);
	logic [7:0]    mem [0:32767];
	logic          dirty = 1'h0;
	logic          storing = 1'h0;
	wire [14:0] #2 a_d = addr_in;
	wire [7:0]  #2 d_d = dq_in;
	wire           rd = !chip_sel_n_in && write_n_in && !out_en_n_in;
	initial dq_out = 8'h5a;
	// a host pulling the pin low locks the array just like a running store
	assign store_busy_n_out = !(busy_drv_in || storing);
	// released bus inverts on each strobe, address or store-busy change so a stale sample cannot pass
	always @(rd or addr_in or store_busy_n_out)
		dq_out = rd && store_busy_n_out ? mem[addr_in] : ~dq_out;
	always @(posedge (chip_sel_n_in | write_n_in))
		if (store_busy_n_out) begin
			mem[a_d] = d_d;
			dirty = 1'h1;
		end
	always @(posedge busy_drv_in)
		if (dirty) begin
			#20;
			storing = 1'h1;
			dirty = 1'h0;
			#500;
			storing = 1'h0;
		end
endmodule // nvsram_model

// >>> bench/test_nvsram_host.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected %0t value mismatch", $time); end end
module test_nvsram_host;
	import nvsram_host_pkg::*;
	logic              clock_in = 1'h0, rst_b_in = 1'h0;
	logic              req_valid_in = 1'h0, req_cmd_sel_in = 1'h0;
	logic              seq_wr_en_in = 1'h0;
	logic [1:0]        req_op_in = 2'h0;
	logic [3:0]        seq_wr_index_in = 4'h0;
	logic [ADDR_W-1:0] req_addr_in = 15'h0, seq_wr_addr_in = 15'h0;
	logic [DATA_W-1:0] req_wdata_in = 8'h0, got;
	logic [ADDR_W-1:0] seen [$];
	logic              rd_q = 1'h0;
	int                n_fail = 0, cmp_count = 0, n_rsp = 0;
	wire               req_ready_out, rsp_valid_out, busy_out;
	wire [DATA_W-1:0]  rsp_rdata_out, mem_dq_in, mem_dq_out, dev_dq;
	wire [ADDR_W-1:0]  mem_addr_out;
	wire               mem_chip_sel_n_out, mem_write_n_out, mem_out_en_n_out;
	wire               mem_dq_oe_out, store_busy_n_in, store_busy_n_out;
	wire               store_busy_n_oe_out;
	wire               rd_now = !mem_chip_sel_n_out && !mem_out_en_n_out;
	assign mem_dq_in = mem_dq_oe_out ? mem_dq_out : dev_dq;
	nvsram_host #(.PROC_CLKS(10), .STORE_WAIT(50)) dut (.*);
	nvsram_model mdl (.addr_in(mem_addr_out),
		.chip_sel_n_in(mem_chip_sel_n_out), .write_n_in(mem_write_n_out),
		.out_en_n_in(mem_out_en_n_out), .dq_in(mem_dq_out),
		.busy_drv_in(store_busy_n_oe_out && !store_busy_n_out),
		.dq_out(dev_dq), .store_busy_n_out(store_busy_n_in));
	initial forever #12.5 clock_in = !clock_in;
	always @(negedge clock_in) begin
		if (rsp_valid_out) begin
			got = rsp_rdata_out;
			n_rsp++;
		end
		if (rd_now && !rd_q)
			seen.push_back(mem_addr_out);
		rd_q = rd_now;
	end
	task automatic req(input logic [1:0] op, input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		req_op_in = op;
		req_addr_in = a;
		req_valid_in = 1'h1;
		while (!req_ready_out && n < 50) begin
			@(negedge clock_in);
			n++;
		end
		req_valid_in = 1'h0;
		while (busy_out !== 1'h0 && n < 200) begin
			@(negedge clock_in);
			n++;
		end
		@(negedge clock_in);
	endtask
	task automatic t_rw;
		req_wdata_in = 8'ha5;
		req(OP_WRITE, 15'h0010);
		req_wdata_in = 8'h3c;
		req(OP_WRITE, 15'h7fff);
		req(OP_READ, 15'h0010);
		`CHK(got, 8'ha5)
		req(OP_READ, 15'h7fff);
		`CHK(got, 8'h3c)
	endtask
	task automatic t_soft;
		int r;
		realtime t0;
		for (int i = 0; i < 2 * SEQ_LEN; i++) begin
			seq_wr_index_in = 4'((i / SEQ_LEN) * 8 + i % SEQ_LEN);
			seq_wr_addr_in = 15'h0a00 + 15'(i * 3);
			seq_wr_en_in = 1'h1;
			@(negedge clock_in);
		end
		seq_wr_en_in = 1'h0;
		req_cmd_sel_in = 1'h1;
		seen.delete();
		r = n_rsp;
		t0 = $realtime;
		req(OP_SOFT_CMD, 15'h0);
		`CHK($realtime - t0 > 25.0 * (4 * SEQ_LEN + 10), 1'h1)
		`CHK(seen.size(), SEQ_LEN)
		for (int s = 0; s < SEQ_LEN; s++)
			`CHK(seen[s], 15'h0a00 + 15'((SEQ_LEN + s) * 3))
		`CHK(n_rsp, r)
	endtask
	// first store has dirty data so the host must wait out the device
	task automatic t_pin;
		realtime t0;
		t0 = $realtime;
		req(OP_PIN_STORE, 15'h0);
		`CHK($realtime - t0 > 500.0, 1'h1)
		req(OP_READ, 15'h0010);
		`CHK(got, 8'ha5)
		t0 = $realtime;
		req(OP_PIN_STORE, 15'h0);
		`CHK($realtime - t0 < 400.0, 1'h1)
	endtask
	task automatic stop_test;
		$display("n_fail %0d cmp_count %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clock_in);
		rst_b_in = 1'h1;
		repeat (2) @(negedge clock_in);
		t_rw();
		t_soft();
		t_pin();
		stop_test();
	end
	initial begin
		#20000;
		n_fail++;
		stop_test();
	end
endmodule // test_nvsram_host

// >>> src/nvsram_host.sv
`timescale 1ns/1ps
// Function
// R1 - device skips store when nothing written since last transfer
// R2 - device still accepts a write for a short grace after store start
// R3 - device ignores accesses during store, recall and low supply
// R4 - command reads end by chip-select or output-enable going high
// R5 - six command addresses read in order with write strobe high
// R6 - each command read cycle lasts at least the slow-grade cycle time
// R7 - data from the sixth command read is discarded
// R8 - device acts on a command within the processing time
// R9 - device locks out the bus until store or recall completes
// R10 - device restores outputs quickly when no write pending
// R11 - pin store request holds store-busy low at least 15 ns
// R12 - array stays inaccessible while store-busy is held low
// R13 - device leaves store-busy undriven if nothing to store
// R14 - pin combinations select standby, write, read, output disabled
// R15 - write grace interval is at most 25 ns
// R16 - device drives store-busy low while a store executes
// R17 - host waits on store-busy or the maximum time before accesses
module nvsram_host
	import nvsram_host_pkg::*;
#(
	parameter int PROC_CLKS  = COMMAND_PROCESSING_CLKS,
	parameter int STORE_WAIT = STORE_CLKS
) (
	input  wire logic              clock_in,
	input  wire logic              rst_b_in,
	input  wire logic              req_valid_in,
	input  wire logic [1:0]        req_op_in,
	input  wire logic [ADDR_W-1:0] req_addr_in,
	input  wire logic [DATA_W-1:0] req_wdata_in,
	input  wire logic              req_cmd_sel_in,
	input  wire logic              seq_wr_en_in,
	input  wire logic [3:0]        seq_wr_index_in,
	input  wire logic [ADDR_W-1:0] seq_wr_addr_in,
	output logic                   req_ready_out,
	output logic                   rsp_valid_out,
	output logic      [DATA_W-1:0] rsp_rdata_out,
	output logic                   busy_out,
	output logic      [ADDR_W-1:0] mem_addr_out,
	output logic                   mem_chip_sel_n_out,
	output logic                   mem_write_n_out,
	output logic                   mem_out_en_n_out,
	input  wire logic [DATA_W-1:0] mem_dq_in,
	output logic      [DATA_W-1:0] mem_dq_out,
	output logic                   mem_dq_oe_out,
	input  wire logic              store_busy_n_in,
	output logic                   store_busy_n_out,
	output logic                   store_busy_n_oe_out
);
	host_state_t       state_q;
	logic [1:0]        op_q;
	logic [2:0]        step_q;
	logic              sel_q;
	logic [WAIT_W-1:0] cnt_q;
	logic [ADDR_W-1:0] rom_data;
	logic [3:0]        rom_index;
	logic              busy_s1_q;
	logic              busy_s2_q;

	assign rom_index = seq_wr_en_in ? seq_wr_index_in : {sel_q, step_q};

	seq_addr_rom #(.DEPTH(16)) u_rom (
		.clock_in    (clock_in),
		.index_in    (rom_index),
		.wr_data_in  (seq_wr_addr_in),
		.wr_en_in    (seq_wr_en_in),
		.rd_data_out (rom_data)
	);

	// pin from the device's domain: two flops before any use
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_s1_q <= 1'h1;
			busy_s2_q <= 1'h1;
		end else begin
			busy_s1_q <= store_busy_n_in;
			busy_s2_q <= busy_s1_q;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= ST_IDLE;
			op_q <= OP_READ;
			step_q <= 3'h0;
			sel_q <= 1'h0;
			cnt_q <= '0;
			req_ready_out <= 1'h0;
			rsp_valid_out <= 1'h0;
			rsp_rdata_out <= 8'h00;
			busy_out <= 1'h1;
			mem_addr_out <= '0;
			mem_chip_sel_n_out <= 1'h1;
			mem_write_n_out <= 1'h1;
			mem_out_en_n_out <= 1'h1;
			mem_dq_out <= 8'h00;
			mem_dq_oe_out <= 1'h0;
			store_busy_n_out <= 1'h1;
			store_busy_n_oe_out <= 1'h0;
		end else begin
			rsp_valid_out <= 1'h0;
			req_ready_out <= 1'h0;
			unique case (state_q)
			ST_IDLE: begin
				busy_out <= 1'h0;
				// no access while the device holds store-busy low
				if (req_valid_in && busy_s2_q) begin // R12 R17
					op_q <= req_op_in;
					sel_q <= req_cmd_sel_in;
					step_q <= 3'h0;
					busy_out <= 1'h1;
					req_ready_out <= 1'h1;
					cnt_q <= WAIT_W'(CYCLE_CLKS);
					unique case (req_op_in)
					OP_PIN_STORE: begin
						store_busy_n_out <= 1'h0; // R11
						store_busy_n_oe_out <= 1'h1;
						cnt_q <= WAIT_W'(STORE_REQUEST_PULSE_CLKS);
						state_q <= ST_PULSE;
					end
					OP_WRITE: begin
						mem_addr_out <= req_addr_in;
						mem_dq_out <= req_wdata_in;
						mem_dq_oe_out <= 1'h1;
						mem_chip_sel_n_out <= 1'h0; // R14
						mem_write_n_out <= 1'h0;
						state_q <= ST_ACCESS;
					end
					OP_READ: begin
						mem_addr_out <= req_addr_in;
						mem_chip_sel_n_out <= 1'h0; // R14
						mem_out_en_n_out <= 1'h0;
						state_q <= ST_ACCESS;
					end
					default: begin
						// rom output registered; address set in ST_END
						state_q <= ST_END;
						cnt_q <= WAIT_W'(1);
					end
					endcase
				end
			end
			ST_ACCESS: begin
				if (cnt_q > WAIT_W'(1)) begin
					cnt_q <= cnt_q - WAIT_W'(1); // R6
				end else begin
					if (op_q != OP_WRITE) begin
						// R7
						if (!(op_q == OP_SOFT_CMD && step_q ==
							3'(SEQ_LEN - 1))) begin
							rsp_rdata_out <= mem_dq_in;
						end
					end
					mem_chip_sel_n_out <= 1'h1; // R4
					mem_out_en_n_out <= 1'h1;
					mem_write_n_out <= 1'h1;
					mem_dq_oe_out <= 1'h0;
					cnt_q <= WAIT_W'(1);
					state_q <= ST_END;
				end
			end
			ST_END: begin
				if (op_q == OP_SOFT_CMD && step_q < 3'(SEQ_LEN) &&
					cnt_q != '0) begin
					// one idle clock lets the rom catch up on step_q
					cnt_q <= '0;
				end else if (op_q == OP_SOFT_CMD &&
					step_q < 3'(SEQ_LEN)) begin
					mem_addr_out <= rom_data; // R5
					mem_write_n_out <= 1'h1;
					mem_chip_sel_n_out <= 1'h0;
					mem_out_en_n_out <= 1'h0;
					cnt_q <= WAIT_W'(CYCLE_CLKS);
					state_q <= ST_ACCESS;
				end else if (op_q == OP_SOFT_CMD &&
					step_q == 3'(SEQ_LEN)) begin
					step_q <= 3'(SEQ_LEN);
					cnt_q <= WAIT_W'(PROC_CLKS);
					state_q <= ST_WAIT_TIME; // R8 R9
				end else begin
					if (op_q != OP_WRITE) begin
						rsp_valid_out <= 1'h1;
					end
					state_q <= ST_IDLE;
				end
			end
			ST_PULSE: begin
				if (cnt_q > WAIT_W'(1)) begin
					cnt_q <= cnt_q - WAIT_W'(1);
				end else begin
					// release; device pulls high or keeps it low
					store_busy_n_oe_out <= 1'h0; // R13 R16
					store_busy_n_out <= 1'h1;
					cnt_q <= WAIT_W'(STORE_WAIT);
					state_q <= ST_WAIT_BUSY;
				end
			end
			ST_WAIT_BUSY: begin
				// settle allowance covers the synchroniser latency
				if (cnt_q == '0 || (busy_s2_q &&
					cnt_q < WAIT_W'(STORE_WAIT) - WAIT_W'(4))) begin
					state_q <= ST_IDLE; // R1 R10 R17
				end else begin
					cnt_q <= cnt_q - WAIT_W'(1);
				end
			end
			ST_WAIT_TIME: begin
				if (cnt_q == '0) begin
					cnt_q <= WAIT_W'(STORE_WAIT);
					state_q <= ST_WAIT_BUSY; // R3 R9
				end else begin
					cnt_q <= cnt_q - WAIT_W'(1);
				end
			end
			default: state_q <= ST_IDLE;
			endcase
			if (state_q == ST_ACCESS && cnt_q <= WAIT_W'(1) &&
				op_q == OP_SOFT_CMD) begin
				step_q <= step_q + 3'h1;
			end
		end
	end
endmodule // nvsram_host

// >>> src/nvsram_host_pkg.sv
package nvsram_host_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CYCLE_TIME_NS = 45;
	localparam int CYCLE_CLKS = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STORE_REQUEST_PULSE_NS = 15;
	localparam int STORE_REQUEST_PULSE_CLKS =
		(STORE_REQUEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COMMAND_PROCESSING_TIME_US = 100;
	localparam int COMMAND_PROCESSING_CLKS =
		COMMAND_PROCESSING_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int STORE_TIME_MS = 8;
	localparam int STORE_CLKS = STORE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SEQ_LEN = 6;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int WAIT_W = 20;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_SOFT_CMD = 2'h2;
	localparam logic [1:0] OP_PIN_STORE = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ACCESS, ST_END, ST_PULSE, ST_WAIT_BUSY, ST_WAIT_TIME
	} host_state_t;
endpackage

// >>> src/seq_addr_rom.sv
`timescale 1ns/1ps
module seq_addr_rom
	import nvsram_host_pkg::*;
#(
	parameter int DEPTH = 2 * SEQ_LEN
) (
	input  wire logic                      clock_in,
	input  wire logic [$clog2(DEPTH)-1:0]  index_in,
	input  wire logic [ADDR_W-1:0]         wr_data_in,
	input  wire logic                      wr_en_in,
	output logic      [ADDR_W-1:0]         rd_data_out
);
	logic [ADDR_W-1:0] mem_q [DEPTH];

	// sequence addresses are loaded by the user, none are built in
	always_ff @(posedge clock_in) begin
		if (wr_en_in) begin
			mem_q[index_in] <= wr_data_in;
		end
		rd_data_out <= mem_q[index_in];
	end
endmodule // seq_addr_rom
